// ---- core/sesl_pkg.sv ----
/*
  Shared constants and types for the serial EEPROM setup loader: timing of
  the serial link, command encodings, EEPROM word map, reset and fixed
  defaults, control bit positions.
  Assumes a 50 MHz system clock and a 64 x 16 three-wire serial EEPROM.
*/
package sesl_pkg;

  // clock and serial timing
  localparam int SYS_CLK_MHZ    = 50;
  localparam int SK_HALF_NS     = 500;
  localparam int SK_HALF_CYC    = (SK_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int WR_TIMEOUT_US  = 10000;
  localparam int WR_TIMEOUT_CYC = WR_TIMEOUT_US * SYS_CLK_MHZ;
  localparam int DIV_W          = 8;
  localparam int WAIT_W         = 19;
  localparam logic [DIV_W-1:0] SK_HALF_LAST = DIV_W'(SK_HALF_CYC - 1);
  localparam logic [WAIT_W-1:0] RDY_SETTLE  = WAIT_W'(SK_HALF_CYC);

  // frame layout: start bit, two opcode bits, six address bits, sixteen data bits
  localparam int FRAME_W = 25;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_EWEN   = 2'h0;
  localparam logic [5:0] EWEN_ADDR = 6'h30;
  localparam logic [4:0] CMD_LAST_BIT  = 5'h08;
  localparam logic [4:0] WR_LAST_BIT   = 5'h18;
  localparam logic [4:0] DATA_LAST_BIT = 5'h0f;

  // EEPROM word map
  localparam logic [2:0] FIXED_SLOT = 3'h7;
  localparam int         SLOT_SHIFT = 2;
  localparam logic [5:0] BASE_OFS   = 6'h01;
  localparam logic [5:0] SA0_ADDR   = 6'h20;
  localparam logic [5:0] SA1_ADDR   = 6'h21;
  localparam logic [5:0] SA2_ADDR   = 6'h22;

  // register defaults
  localparam logic [15:0] CFG_RESET  = 16'h0000;
  localparam logic [15:0] BASE_RESET = 16'h0000;
  localparam logic [15:0] SA_RESET   = 16'h0000;
  localparam logic [15:0] GP_RESET   = 16'h0000;
  localparam logic [7:0]  PTR_RESET  = 8'h00;
  localparam logic [15:0] CFG_FIXED  = 16'h0001;
  localparam logic [15:0] BASE_FIXED = 16'h1300;

  // control register bit positions
  localparam int CTL_SEL_BIT    = 0;
  localparam int CTL_RELOAD_BIT = 1;
  localparam int CTL_STORE_BIT  = 2;

  // start-up wait so that synchronised straps are valid
  localparam logic [2:0] SETTLE_LAST = 3'h5;

  // step indices of the job sequences
  localparam logic [2:0] STEP_CFG  = 3'h0;
  localparam logic [2:0] STEP_BASE = 3'h1;
  localparam logic [2:0] STEP_SA0  = 3'h2;
  localparam logic [2:0] STEP_SA1  = 3'h3;
  localparam logic [2:0] STEP_SA2  = 3'h4;
  localparam logic [2:0] STEP_EWEN = 3'h0;
  localparam logic [2:0] STEP_WR_A = 3'h1;
  localparam logic [2:0] STEP_WR_B = 3'h2;

  typedef enum logic [1:0] {SESL_CMD_READ, SESL_CMD_WRITE, SESL_CMD_EWEN} sesl_cmd_type;
  typedef enum logic [1:0] {SESL_LOAD_ALL, SESL_LOAD_GP, SESL_STORE_CFG,
                            SESL_STORE_GP} sesl_job_type;
  typedef enum logic [2:0] {SESL_DST_NONE, SESL_DST_CFG, SESL_DST_BASE, SESL_DST_SA0,
                            SESL_DST_SA1, SESL_DST_SA2, SESL_DST_GP} sesl_dest_type;

endpackage

// ---- core/sesl_mw_engine.sv ----
/*
  Three-wire serial EEPROM engine: sends one read, write or write-enable
  frame and, for a write, waits for the part to report ready on its data out.
  Assumes the caller pulses start only while idle and waits for done.
*/
`timescale 1ns/1ps
module sesl_mw_engine #(
  parameter int WR_TIMEOUT_CYCLES = sesl_pkg::WR_TIMEOUT_CYC
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  start,
  input  sesl_pkg::sesl_cmd_type     cmd,
  input  wire logic [5:0]            addr,
  input  wire logic [15:0]           wdata,
  output logic      [15:0]           rdata,
  output logic                       done,
  output logic                       eep_cs,
  output logic                       eep_sk,
  output logic                       eep_di,
  input  wire logic                  eep_do
);

  localparam logic [sesl_pkg::WAIT_W-1:0] TMO_LAST = sesl_pkg::WAIT_W'(WR_TIMEOUT_CYCLES - 1);

  typedef enum logic [2:0] {SESL_E_IDLE, SESL_E_SHIFT, SESL_E_RDATA, SESL_E_GAP,
                            SESL_E_WAITRDY, SESL_E_END} sesl_eng_state_type;

  sesl_eng_state_type                state_q, state_d;
  sesl_pkg::sesl_cmd_type            cmd_q, cmd_d;
  logic [sesl_pkg::DIV_W-1:0]        div_q, div_d;
  logic [sesl_pkg::WAIT_W-1:0]       wait_q, wait_d;
  logic [sesl_pkg::FRAME_W-1:0]      sh_q, sh_d;
  logic [4:0]                        cnt_q, cnt_d;
  logic [15:0]                       rd_q, rd_d;
  logic                              sk_q, sk_d;
  logic                              cs_q, cs_d;
  logic                              di_q, di_d;
  logic                              done_q, done_d;
  logic                              do_s1_q, do_s2_q, do_s3_q, do_f_q;
  logic                              tick;
  logic [1:0]                        op;
  logic [5:0]                        fr_addr;

  assign tick   = (div_q == sesl_pkg::SK_HALF_LAST);
  assign rdata  = rd_q;
  assign done   = done_q;
  assign eep_cs = cs_q;
  assign eep_sk = sk_q;
  assign eep_di = di_q;

  always_comb begin
    state_d = state_q;
    cmd_d   = cmd_q;
    div_d   = tick ? '0 : div_q + 1'b1;
    wait_d  = wait_q;
    sh_d    = sh_q;
    cnt_d   = cnt_q;
    rd_d    = rd_q;
    sk_d    = sk_q;
    cs_d    = cs_q;
    di_d    = di_q;
    done_d  = 1'b0;
    op      = sesl_pkg::OP_READ;
    fr_addr = addr;
    case (cmd)
      sesl_pkg::SESL_CMD_WRITE: op = sesl_pkg::OP_WRITE;
      sesl_pkg::SESL_CMD_EWEN: begin
        op      = sesl_pkg::OP_EWEN;
        fr_addr = sesl_pkg::EWEN_ADDR;
      end
      default: op = sesl_pkg::OP_READ;
    endcase
    case (state_q)
      SESL_E_IDLE: begin
        div_d = '0;
        sk_d  = 1'b0;
        if (start) begin
          sh_d    = {1'b1, op, fr_addr, wdata};
          cnt_d   = (cmd == sesl_pkg::SESL_CMD_WRITE) ? sesl_pkg::WR_LAST_BIT
                                                      : sesl_pkg::CMD_LAST_BIT;
          cmd_d   = cmd;
          cs_d    = 1'b1;
          di_d    = 1'b1;
          state_d = SESL_E_SHIFT;
        end
      end
      SESL_E_SHIFT: if (tick) begin
        sk_d = ~sk_q;
        if (sk_q) begin
          if (cnt_q == 5'h00) begin
            di_d = 1'b0;
            case (cmd_q)
              sesl_pkg::SESL_CMD_READ: begin
                cnt_d   = sesl_pkg::DATA_LAST_BIT;
                state_d = SESL_E_RDATA;
              end
              sesl_pkg::SESL_CMD_WRITE: begin
                cs_d    = 1'b0;
                state_d = SESL_E_GAP;
              end
              default: begin
                cs_d    = 1'b0;
                state_d = SESL_E_END;
              end
            endcase
          end else begin
            cnt_d = cnt_q - 1'b1;
            sh_d  = {sh_q[sesl_pkg::FRAME_W-2:0], 1'b0};
            di_d  = sh_q[sesl_pkg::FRAME_W-2];
          end
        end
      end
      SESL_E_RDATA: if (tick) begin
        sk_d = ~sk_q;
        if (sk_q) begin
          // sample at the end of the high phase, one full half period after the rise
          rd_d = {rd_q[14:0], do_f_q};
          if (cnt_q == 5'h00) begin
            cs_d    = 1'b0;
            state_d = SESL_E_END;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
      end
      SESL_E_GAP: if (tick) begin
        cs_d    = 1'b1;
        wait_d  = '0;
        state_d = SESL_E_WAITRDY;
      end
      SESL_E_WAITRDY: begin
        wait_d = wait_q + 1'b1;
        // ready shows as data out high; a timeout ends a dead write
        if ((wait_q >= sesl_pkg::RDY_SETTLE && do_f_q) || wait_q == TMO_LAST) begin
          cs_d    = 1'b0;
          state_d = SESL_E_END;
        end
      end
      SESL_E_END: begin
        done_d  = 1'b1;
        state_d = SESL_E_IDLE;
      end
      default: state_d = SESL_E_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_q <= SESL_E_IDLE;
      cmd_q   <= sesl_pkg::SESL_CMD_READ;
      div_q   <= '0;
      wait_q  <= '0;
      sh_q    <= '0;
      cnt_q   <= 5'h00;
      rd_q    <= 16'h0000;
      sk_q    <= 1'b0;
      cs_q    <= 1'b0;
      di_q    <= 1'b0;
      done_q  <= 1'b0;
      do_s1_q <= 1'b0;
      do_s2_q <= 1'b0;
      do_s3_q <= 1'b0;
      do_f_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cmd_q   <= cmd_d;
      div_q   <= div_d;
      wait_q  <= wait_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      rd_q    <= rd_d;
      sk_q    <= sk_d;
      cs_q    <= cs_d;
      di_q    <= di_d;
      done_q  <= done_d;
      do_s1_q <= eep_do;
      do_s2_q <= do_s1_q;
      do_s3_q <= do_s2_q;
      if (do_s2_q == do_s3_q) begin
        do_f_q <= do_s2_q;
      end
    end
  end

endmodule

// ---- core/sesl_loader.sv ----
/*
  Setup loader top: fetches configuration, base and station address words
  from a serial EEPROM after reset and on request, stores config and base back, and
  gives single-word access through a general purpose register and pointer.
  Assumes host register accesses arrive as one-cycle write strobes on the
  system clock; straps, presence and EEPROM data out are asynchronous pins.
*/
`timescale 1ns/1ps
// Operation
// - fetch setup words automatically after reset
// - config at strap times four, base next
// - station address from words 20h-22h always
// - strap seven: station address only, fixed defaults
// - all straps high select fixed defaults
// - EEPROM is 64 words, whole-word access
// - select 0 fetch reloads config, base, station
// - select 0 store writes config and base, except with strap seven (nothing is written)
// - select, fetch, store are control bits 0-2
// - select 1 fetch reads pointed word to gp
// - select 1 store writes gp to pointed word
// - busy: triggers read high, other access locked
// - busy lockout also during reset reload
// - no EEPROM: never access, defaults kept
module sesl_loader #(
  parameter int WR_TIMEOUT_CYCLES = sesl_pkg::WR_TIMEOUT_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  setup_slot_straps,
  input  wire logic        rom_present_input,
  input  wire logic        ctl_wr,
  input  wire logic [2:0]  ctl_wdata,
  input  wire logic        cfg_wr,
  input  wire logic [15:0] cfg_wdata,
  input  wire logic        base_wr,
  input  wire logic [15:0] base_wdata,
  input  wire logic [2:0]  sa_wr,
  input  wire logic [15:0] sa_wdata,
  input  wire logic        gp_wr,
  input  wire logic [15:0] gp_wdata,
  input  wire logic        ptr_wr,
  input  wire logic [7:0]  ptr_wdata,
  output logic             ctl_select,
  output logic             ctl_reload,
  output logic             ctl_store,
  output logic             regs_locked,
  output logic [15:0]      config_reg,
  output logic [15:0]      base_reg,
  output logic [15:0]      station_addr_word0,
  output logic [15:0]      station_addr_word1,
  output logic [15:0]      station_addr_word2,
  output logic [15:0]      gp_reg,
  output logic [7:0]       pointer_reg,
  output logic             eep_cs,
  output logic             eep_sk,
  output logic             eep_di,
  input  wire logic        eep_do
);

  typedef enum logic [1:0] {SESL_SETTLE, SESL_IDLE, SESL_ISSUE, SESL_WAIT} sesl_state_type;

  sesl_state_type          st_q, st_d;
  sesl_pkg::sesl_job_type  job_q, job_d;
  logic [2:0]              step_q, step_d;
  logic [2:0]              settle_q, settle_d;
  logic                    busy_q, busy_d;
  logic                    sel_q, sel_d;
  logic                    start_q, start_d;
  logic [15:0]             cfg_q, cfg_d;
  logic [15:0]             base_q, base_d;
  logic [15:0]             sa0_q, sa0_d;
  logic [15:0]             sa1_q, sa1_d;
  logic [15:0]             sa2_q, sa2_d;
  logic [15:0]             gp_q, gp_d;
  logic [7:0]              ptr_q, ptr_d;
  logic [2:0]              strap_s1_q, strap_s2_q, strap_s3_q, strap_f_q;
  logic                    pres_s1_q, pres_s2_q, pres_s3_q, pres_f_q;

  sesl_pkg::sesl_cmd_type  step_cmd;
  sesl_pkg::sesl_dest_type step_dest;
  logic [5:0]              step_addr;
  logic [15:0]             step_wdata;
  logic                    step_last;
  logic [5:0]              slot_addr;
  logic                    fixed_slot;
  logic [15:0]             eng_rdata;
  logic                    eng_done;

  assign slot_addr  = 6'({3'h0, strap_f_q} << sesl_pkg::SLOT_SHIFT);
  assign fixed_slot = (strap_f_q == sesl_pkg::FIXED_SLOT);

  assign ctl_select         = sel_q;
  assign ctl_reload         = busy_q;
  assign ctl_store          = busy_q;
  assign regs_locked        = busy_q;
  assign config_reg         = cfg_q;
  assign base_reg           = base_q;
  assign station_addr_word0 = sa0_q;
  assign station_addr_word1 = sa1_q;
  assign station_addr_word2 = sa2_q;
  assign gp_reg             = gp_q;
  assign pointer_reg        = ptr_q;

  // what the current step of the running job does
  always_comb begin
    step_cmd   = sesl_pkg::SESL_CMD_READ;
    step_addr  = sesl_pkg::SA0_ADDR;
    step_wdata = 16'h0000;
    step_dest  = sesl_pkg::SESL_DST_NONE;
    step_last  = 1'b0;
    case (job_q)
      sesl_pkg::SESL_LOAD_ALL: begin
        case (step_q)
          sesl_pkg::STEP_CFG: begin
            step_addr = slot_addr;
            step_dest = sesl_pkg::SESL_DST_CFG;
          end
          sesl_pkg::STEP_BASE: begin
            step_addr = slot_addr + sesl_pkg::BASE_OFS;
            step_dest = sesl_pkg::SESL_DST_BASE;
          end
          sesl_pkg::STEP_SA0: begin
            step_addr = sesl_pkg::SA0_ADDR;
            step_dest = sesl_pkg::SESL_DST_SA0;
          end
          sesl_pkg::STEP_SA1: begin
            step_addr = sesl_pkg::SA1_ADDR;
            step_dest = sesl_pkg::SESL_DST_SA1;
          end
          default: begin
            step_addr = sesl_pkg::SA2_ADDR;
            step_dest = sesl_pkg::SESL_DST_SA2;
            step_last = 1'b1;
          end
        endcase
      end
      sesl_pkg::SESL_LOAD_GP: begin
        step_addr = ptr_q[5:0];
        step_dest = sesl_pkg::SESL_DST_GP;
        step_last = 1'b1;
      end
      sesl_pkg::SESL_STORE_CFG: begin
        case (step_q)
          sesl_pkg::STEP_EWEN: step_cmd = sesl_pkg::SESL_CMD_EWEN;
          sesl_pkg::STEP_WR_A: begin
            step_cmd   = sesl_pkg::SESL_CMD_WRITE;
            step_addr  = slot_addr;
            step_wdata = cfg_q;
          end
          default: begin
            step_cmd   = sesl_pkg::SESL_CMD_WRITE;
            step_addr  = slot_addr + sesl_pkg::BASE_OFS;
            step_wdata = base_q;
            step_last  = 1'b1;
          end
        endcase
      end
      default: begin
        if (step_q == sesl_pkg::STEP_EWEN) begin
          step_cmd = sesl_pkg::SESL_CMD_EWEN;
        end else begin
          step_cmd   = sesl_pkg::SESL_CMD_WRITE;
          step_addr  = ptr_q[5:0];
          step_wdata = gp_q;
          step_last  = 1'b1;
        end
      end
    endcase
  end

  always_comb begin
    st_d     = st_q;
    job_d    = job_q;
    step_d   = step_q;
    settle_d = settle_q;
    busy_d   = busy_q;
    sel_d    = sel_q;
    start_d  = 1'b0;
    cfg_d    = cfg_q;
    base_d   = base_q;
    sa0_d    = sa0_q;
    sa1_d    = sa1_q;
    sa2_d    = sa2_q;
    gp_d     = gp_q;
    ptr_d    = ptr_q;
    case (st_q)
      SESL_SETTLE: begin
        // held busy until the straps are sampled and, with a part present, the reload is done
        if (settle_q == sesl_pkg::SETTLE_LAST) begin
          if (pres_f_q) begin
            job_d  = sesl_pkg::SESL_LOAD_ALL;
            step_d = fixed_slot ? sesl_pkg::STEP_SA0 : sesl_pkg::STEP_CFG;
            if (fixed_slot) begin
              cfg_d  = sesl_pkg::CFG_FIXED;
              base_d = sesl_pkg::BASE_FIXED;
            end
            st_d = SESL_ISSUE;
          end else begin
            busy_d = 1'b0;
            st_d   = SESL_IDLE;
          end
        end else begin
          settle_d = settle_q + 1'b1;
        end
      end
      SESL_IDLE: begin
        // host writes only land here, so nothing is accepted while busy
        if (cfg_wr) cfg_d = cfg_wdata;
        if (base_wr) base_d = base_wdata;
        if (sa_wr[0]) sa0_d = sa_wdata;
        if (sa_wr[1]) sa1_d = sa_wdata;
        if (sa_wr[2]) sa2_d = sa_wdata;
        if (gp_wr) gp_d = gp_wdata;
        if (ptr_wr) ptr_d = ptr_wdata;
        if (ctl_wr) begin
          sel_d = ctl_wdata[sesl_pkg::CTL_SEL_BIT];
          if (pres_f_q && ctl_wdata[sesl_pkg::CTL_RELOAD_BIT]) begin
            busy_d = 1'b1;
            st_d   = SESL_ISSUE;
            if (ctl_wdata[sesl_pkg::CTL_SEL_BIT]) begin
              job_d  = sesl_pkg::SESL_LOAD_GP;
              step_d = sesl_pkg::STEP_CFG;
            end else begin
              job_d  = sesl_pkg::SESL_LOAD_ALL;
              step_d = fixed_slot ? sesl_pkg::STEP_SA0 : sesl_pkg::STEP_CFG;
              if (fixed_slot) begin
                cfg_d  = sesl_pkg::CFG_FIXED;
                base_d = sesl_pkg::BASE_FIXED;
              end
            end
          end else if (pres_f_q && ctl_wdata[sesl_pkg::CTL_STORE_BIT]) begin
            if (ctl_wdata[sesl_pkg::CTL_SEL_BIT]) begin
              busy_d = 1'b1;
              st_d   = SESL_ISSUE;
              job_d  = sesl_pkg::SESL_STORE_GP;
              step_d = sesl_pkg::STEP_EWEN;
            end else if (!fixed_slot) begin
              busy_d = 1'b1;
              st_d   = SESL_ISSUE;
              job_d  = sesl_pkg::SESL_STORE_CFG;
              step_d = sesl_pkg::STEP_EWEN;
            end
          end
        end
      end
      SESL_ISSUE: begin
        start_d = 1'b1;
        st_d    = SESL_WAIT;
      end
      SESL_WAIT: begin
        if (eng_done) begin
          case (step_dest)
            sesl_pkg::SESL_DST_CFG:  cfg_d  = eng_rdata;
            sesl_pkg::SESL_DST_BASE: base_d = eng_rdata;
            sesl_pkg::SESL_DST_SA0:  sa0_d  = eng_rdata;
            sesl_pkg::SESL_DST_SA1:  sa1_d  = eng_rdata;
            sesl_pkg::SESL_DST_SA2:  sa2_d  = eng_rdata;
            sesl_pkg::SESL_DST_GP:   gp_d   = eng_rdata;
            default: ;
          endcase
          if (step_last) begin
            busy_d = 1'b0;
            st_d   = SESL_IDLE;
          end else begin
            step_d = step_q + 1'b1;
            st_d   = SESL_ISSUE;
          end
        end
      end
      default: st_d = SESL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_q       <= SESL_SETTLE;
      job_q      <= sesl_pkg::SESL_LOAD_ALL;
      step_q     <= sesl_pkg::STEP_CFG;
      settle_q   <= 3'h0;
      busy_q     <= 1'b1;
      sel_q      <= 1'b0;
      start_q    <= 1'b0;
      cfg_q      <= sesl_pkg::CFG_RESET;
      base_q     <= sesl_pkg::BASE_RESET;
      sa0_q      <= sesl_pkg::SA_RESET;
      sa1_q      <= sesl_pkg::SA_RESET;
      sa2_q      <= sesl_pkg::SA_RESET;
      gp_q       <= sesl_pkg::GP_RESET;
      ptr_q      <= sesl_pkg::PTR_RESET;
      strap_s1_q <= 3'h0;
      strap_s2_q <= 3'h0;
      strap_s3_q <= 3'h0;
      strap_f_q  <= 3'h0;
      pres_s1_q  <= 1'b0;
      pres_s2_q  <= 1'b0;
      pres_s3_q  <= 1'b0;
      pres_f_q   <= 1'b0;
    end else begin
      st_q       <= st_d;
      job_q      <= job_d;
      step_q     <= step_d;
      settle_q   <= settle_d;
      busy_q     <= busy_d;
      sel_q      <= sel_d;
      start_q    <= start_d;
      cfg_q      <= cfg_d;
      base_q     <= base_d;
      sa0_q      <= sa0_d;
      sa1_q      <= sa1_d;
      sa2_q      <= sa2_d;
      gp_q       <= gp_d;
      ptr_q      <= ptr_d;
      strap_s1_q <= setup_slot_straps;
      strap_s2_q <= strap_s1_q;
      strap_s3_q <= strap_s2_q;
      if (strap_s2_q == strap_s3_q) begin
        strap_f_q <= strap_s2_q;
      end
      pres_s1_q  <= rom_present_input;
      pres_s2_q  <= pres_s1_q;
      pres_s3_q  <= pres_s2_q;
      if (pres_s2_q == pres_s3_q) begin
        pres_f_q <= pres_s2_q;
      end
    end
  end

  sesl_mw_engine #(
    .WR_TIMEOUT_CYCLES (WR_TIMEOUT_CYCLES)
  ) u_engine (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .start   (start_q),
    .cmd     (step_cmd),
    .addr    (step_addr),
    .wdata   (step_wdata),
    .rdata   (eng_rdata),
    .done    (eng_done),
    .eep_cs  (eep_cs),
    .eep_sk  (eep_sk),
    .eep_di  (eep_di),
    .eep_do  (eep_do)
  );

endmodule

// ---- dv/sesl_eep_model.sv ----
/* behavioural 64 x 16 three-wire serial EEPROM
   assumes the loader drives cs, sk and di */
`timescale 1ns/1ps
module sesl_eep_model (
  input  wire logic eep_cs,
  input  wire logic eep_sk,
  input  wire logic eep_di,
  output logic      eep_do
);
  logic [15:0] mem [64];
  logic [8:0]  cmd;
  logic [15:0] dat;
  logic        wen;
  logic        pend;
  int          cnt;
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 16'h3c00 + 16'(i);
    end
    {eep_do, wen, pend, cmd} = '0;
    cnt = 0;
  end
  // ready only after a write; otherwise the released line flips
  always @(posedge eep_cs) begin
    cnt = 0;
    eep_do = pend | ~eep_do;
    pend = 1'b0;
  end
  always @(negedge eep_cs) begin
    if (cmd[7:6] == sesl_pkg::OP_EWEN && cmd[5:4] == 2'h3) begin
      wen = 1'b1;
    end
    if (cmd[7:6] == sesl_pkg::OP_WRITE && cnt == 25 && wen) begin
      mem[cmd[5:0]] = dat;
      pend = 1'b1;
    end
    eep_do = ~eep_do;
  end
  always @(posedge eep_sk) begin
    if (eep_cs) begin
      cnt++;
      cmd = (cnt <= 9) ? {cmd[7:0], eep_di} : cmd;
      dat = {dat[14:0], eep_di};
      if (cmd[7:6] == sesl_pkg::OP_READ && cnt >= 9 && cnt <= 25) begin
        eep_do = (cnt == 9) ? 1'b0 : mem[cmd[5:0]][25 - cnt];
      end
    end
  end
endmodule

// ---- dv/sesl_loader_asserts.sv ----
/* port assertions for the setup loader
   bound to every sesl_loader instance */
`timescale 1ns/1ps
module sesl_loader_asserts (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       rom_present_input,
  input wire logic       ctl_wr,
  input wire logic [2:0] ctl_wdata,
  input wire logic       ctl_select,
  input wire logic       ctl_reload,
  input wire logic       ctl_store,
  input wire logic       regs_locked,
  input wire logic       eep_cs,
  input wire logic       eep_sk,
  input wire logic       eep_di
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_host;
    ctl_wr && !regs_locked;
  endsequence
  sequence s_frame;
    $rose(eep_cs);
  endsequence
  a_busy_pair: assert property (
    ctl_reload == ctl_store && ctl_store == regs_locked) else $error("busy bits differ");
  a_fetch_busy: assert property (
    s_host ##0 ctl_wdata[1] && rom_present_input |=> ctl_reload) else $error("no busy");
  a_sel_kept: assert property (
    s_host |=> ctl_select == $past(ctl_wdata[0])) else $error("select lost");
  a_cs_busy: assert property (
    eep_cs |-> regs_locked) else $error("access while unlocked");
  a_no_rom: assert property (
    (!rom_present_input)[*8] |-> !eep_cs) else $error("access without part");
  a_frame_start: assert property (
    s_frame |-> !eep_sk) else $error("frame starts with clock high");
  a_di_steady: assert property (
    $rose(eep_sk) |-> $stable(eep_di)) else $error("data moved at clock rise");
  a_sk_framed: assert property (
    !eep_cs |-> !eep_sk) else $error("clock outside frame");
endmodule
bind sesl_loader sesl_loader_asserts i_chk (.sys_clk, .rstn, .rom_present_input, .ctl_wr,
  .ctl_wdata, .ctl_select, .ctl_reload, .ctl_store, .regs_locked, .eep_cs, .eep_sk, .eep_di);

// ---- dv/test_sesl_loader.sv ----
/* bench for the setup loader with its EEPROM model
   assumes a 50 MHz clock */
`timescale 1ns/1ps
module test_sesl_loader;
  logic        sys_clk, rstn, rom_present_input, eep_cs, eep_sk, eep_di, eep_do;
  logic        ctl_wr, cfg_wr, base_wr, gp_wr, ptr_wr, ctl_select, ctl_reload;
  logic        ctl_store, regs_locked;
  logic [2:0]  setup_slot_straps, ctl_wdata, sa_wr;
  logic [7:0]  ptr_wdata, pointer_reg;
  logic [15:0] cfg_wdata, base_wdata, sa_wdata, gp_wdata, config_reg, base_reg, gp_reg;
  logic [15:0] station_addr_word0, station_addr_word1, station_addr_word2;
  int          err_total, num_checks;
  sesl_loader #(.WR_TIMEOUT_CYCLES(200)) i_dut (.sys_clk, .rstn, .setup_slot_straps,
    .rom_present_input, .ctl_wr, .ctl_wdata, .cfg_wr, .cfg_wdata, .base_wr, .base_wdata,
    .sa_wr, .sa_wdata, .gp_wr, .gp_wdata, .ptr_wr, .ptr_wdata, .ctl_select, .ctl_reload,
    .ctl_store, .regs_locked, .config_reg, .base_reg, .station_addr_word0,
    .station_addr_word1, .station_addr_word2, .gp_reg, .pointer_reg, .eep_cs, .eep_sk,
    .eep_di, .eep_do);
  sesl_eep_model i_eep (.eep_cs, .eep_sk, .eep_di, .eep_do);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic chk(string what, logic [87:0] seen, logic [87:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 9999 && regs_locked !== 1'b0; n++) @(negedge sys_clk);
    if (n == 9999) begin
      err_total++;
      tally_and_finish;
    end
  endtask
  // strobes set by the caller at this edge land with the trigger
  task automatic go(logic [2:0] c);
    ctl_wr <= 1'b1;
    ctl_wdata <= c;
    @(posedge sys_clk);
    {ctl_wr, cfg_wr, base_wr, gp_wr, ptr_wr} <= '0;
    @(negedge sys_clk);
    chk("busy", {ctl_reload, ctl_store}, {2{rom_present_input}});
    wait_idle;
  endtask
  task automatic t_reset_load;
    @(posedge sys_clk);
    ptr_wr <= 1'b1;
    ptr_wdata <= 8'h3f;
    @(posedge sys_clk);
    ptr_wr <= 1'b0;
    wait_idle;
    chk("load", {config_reg, base_reg, station_addr_word0, station_addr_word1,
      station_addr_word2, pointer_reg}, 88'h3c08_3c09_3c20_3c21_3c22_00);
  endtask
  task automatic t_gp_word;
    @(posedge sys_clk);
    ptr_wr <= 1'b1;
    ptr_wdata <= 8'hc5;
    go(3'h3);
    chk("gp", {gp_reg, ctl_select}, {16'h3c05, 1'b1});
    @(posedge sys_clk);
    gp_wr <= 1'b1;
    gp_wdata <= 16'hbeef;
    go(3'h5);
    chk("word5", i_eep.mem[5], 16'hbeef);
  endtask
  task automatic t_store_pair;
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= 16'h1234;
    base_wr <= 1'b1;
    base_wdata <= 16'h5678;
    go(3'h4);
    chk("pair", {i_eep.mem[8], i_eep.mem[9]}, 32'h1234_5678);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= 16'h0000;
    go(3'h2);
    chk("cfg", config_reg, 16'h1234);
    // both triggers at once: the fetch runs, the pair in the EEPROM is kept
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_wdata <= 16'haaaa;
    go(3'h6);
    chk("both", {config_reg, i_eep.mem[8]}, 32'h1234_1234);
    @(posedge sys_clk);
    setup_slot_straps <= 3'h7;
    repeat (8) @(posedge sys_clk);
    go(3'h2);
    chk("fixed", {config_reg, base_reg}, {sesl_pkg::CFG_FIXED, sesl_pkg::BASE_FIXED});
  endtask
  task automatic t_no_rom;
    @(posedge sys_clk);
    rstn <= 1'b0;
    rom_present_input <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    wait_idle;
    chk("none", {config_reg, base_reg, station_addr_word0}, 48'h0);
    // without a part the host programs the station address itself
    @(posedge sys_clk);
    sa_wr <= 3'h2;
    sa_wdata <= 16'h0a0b;
    @(posedge sys_clk);
    sa_wr <= 3'h0;
    @(negedge sys_clk);
    chk("sa_host", {station_addr_word0, station_addr_word1}, 32'h0000_0a0b);
    @(posedge sys_clk);
    go(3'h2);
  endtask
  initial begin
    {rstn, ctl_wr, cfg_wr, base_wr, gp_wr, ptr_wr, sa_wr, ctl_wdata} = '0;
    {cfg_wdata, base_wdata, sa_wdata, gp_wdata, ptr_wdata} = '0;
    setup_slot_straps = 3'h2;
    rom_present_input = 1'b1;
    err_total = 0;
    num_checks = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset_load;
    t_gp_word;
    t_store_pair;
    t_no_rom;
    tally_and_finish;
  end
endmodule
